// *** hdl/bridge_window_and_control_regs.sv ***
`timescale 1ns/10ps
// Functional notes
// - a 32-bit read/write register, reset to zero, holds the top half of the prefetch limit.
// - a 32-bit read/write register, reset to zero, holds the top half of the prefetch base.
// - a 16-bit read/write field, reset to zero, gives bits 31 to 16 of the I/O window base.
// - a read/write field, reset to zero, gives bits 31 to 16 of the I/O window limit.
// - I/O base and limit with their upper extensions decide whether I/O crosses the bridge.
// - the capability list pointer always reads back DCh.
// - the interrupt pin field in bits 15 to 8 is read-only, reports no pin, ignores writes.
// - control bit 16, reset zero, enables detection and reporting of secondary parity errors.
// - control bit 17, reset zero, lets a secondary system error reach the primary side.
// - with bit 18 clear, every I/O address in the window goes downstream unfiltered.
// - with bit 18 set, in-window I/O in the first 64KB in the last 768 bytes of 1KB stays up unless it is VGA I/O with bit 19 set.
// - with bit 18 set, secondary I/O in the first 64KB in the last 768 bytes of a 1KB block goes upstream unless it is VGA I/O with bit 19 set.
// - with bit 19 clear, VGA memory and I/O addresses pass downstream only when the windows pass them.
// - with bit 19 set, VGA memory and I/O addresses pass downstream regardless of windows.
// - control bit 20 is reserved, read-only and always reads zero.
module bridge_window_and_control_regs
  import bridge_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // lower window bits held by neighbouring registers
  input wire logic [3:0] io_base_low_i,
  input wire logic [3:0] io_limit_low_i,
  input wire logic [11:0] pf_base_low_i,
  input wire logic [11:0] pf_limit_low_i,
  // primary side forwarding query
  input wire logic pri_valid_i,
  input wire logic pri_is_io_i,
  input wire logic [63:0] pri_addr_i,
  output logic pri_done_o,
  output logic pri_forward_o,
  // secondary side I/O forwarding query
  input wire logic sec_valid_i,
  input wire logic [31:0] sec_addr_i,
  output logic sec_done_o,
  output logic sec_forward_o,
  // secondary error handling
  input wire logic sec_parity_error_i,
  input wire logic secondary_system_error_n_i,
  output logic parity_report_o,
  output logic primary_system_error_n_o,
  output logic irq_o
);
  logic [31:0] pf_base_high_q;
  logic [31:0] pf_limit_high_q;
  logic [15:0] io_base_high_q;
  logic [15:0] io_limit_high_q;
  logic [7:0] int_line_q;
  logic parity_en_q;
  logic serr_en_q;
  logic isa_en_q;
  logic vga_en_q;
  logic [31:0] rdata_q;
  logic pri_done_q;
  logic pri_forward_q;
  logic sec_done_q;
  logic sec_forward_q;
  logic parity_report_q;
  logic serr_n_q;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  logic [63:0] pf_base;
  logic [63:0] pf_limit;
  logic pri_io_hit;
  logic sec_io_hit;
  logic pf_hit;
  logic pri_fwd_d;
  logic sec_fwd_d;
  logic vga_hit;
  logic [IRQ_NUM-1:0] irq_event;
  logic [IRQ_NUM-1:0] irq_status;
  logic [IRQ_NUM-1:0] irq_mask;
  logic status_wr;
  logic mask_wr;
  logic [31:0] rdata_d;

  // prefetch limit upper half
  // limit high store
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      pf_limit_high_q <= PF_HIGH_RESET;
    else if (wr_i && addr_i == OFF_PF_LIMIT_HIGH)
      pf_limit_high_q <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      pf_base_high_q <= PF_HIGH_RESET;
    else if (wr_i && addr_i == OFF_PF_BASE_HIGH)
      pf_base_high_q <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      io_base_high_q <= IO_HIGH_RESET;
      io_limit_high_q <= IO_HIGH_RESET;
    end
    else if (wr_i && addr_i == OFF_IO_HIGH)
    begin
      io_base_high_q <= wdata_i[IO_BASE_LSB +: 16];
      io_limit_high_q <= wdata_i[IO_LIMIT_LSB +: 16];
    end
  end

  // interrupt line and control bits; pin field has no storage
  // pin write ignored
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      int_line_q <= INT_LINE_RESET;
    else if (wr_i && addr_i == OFF_INT_CTRL)
      int_line_q <= wdata_i[INT_LINE_LSB +: 8];
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      parity_en_q <= CTRL_RESET[0];
    else if (wr_i && addr_i == OFF_INT_CTRL)
      parity_en_q <= wdata_i[CTRL_PARITY_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      serr_en_q <= CTRL_RESET[1];
    else if (wr_i && addr_i == OFF_INT_CTRL)
      serr_en_q <= wdata_i[CTRL_SERR_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      isa_en_q <= CTRL_RESET[2];
    else if (wr_i && addr_i == OFF_INT_CTRL)
      isa_en_q <= wdata_i[CTRL_ISA_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      vga_en_q <= CTRL_RESET[3];
    else if (wr_i && addr_i == OFF_INT_CTRL)
      vga_en_q <= wdata_i[CTRL_VGA_BIT];
  end

  // window assembly
  // io window with extension
  assign io_base = {io_base_high_q, io_base_low_i, IO_LOW_ZERO};
  assign io_limit = {io_limit_high_q, io_limit_low_i, IO_LOW_ONES};
  assign pf_base = {pf_base_high_q, pf_base_low_i, PF_LOW_ZERO};
  assign pf_limit = {pf_limit_high_q, pf_limit_low_i, PF_LOW_ONES};

  window_compare #(.W(32)) u_pri_io
  (
    .addr_i(pri_addr_i[31:0]),
    .base_i(io_base),
    .limit_i(io_limit),
    .hit_o(pri_io_hit)
  );

  window_compare #(.W(32)) u_sec_io
  (
    .addr_i(sec_addr_i),
    .base_i(io_base),
    .limit_i(io_limit),
    .hit_o(sec_io_hit)
  );

  window_compare #(.W(64)) u_pf
  (
    .addr_i(pri_addr_i),
    .base_i(pf_base),
    .limit_i(pf_limit),
    .hit_o(pf_hit)
  );

  // vga compatible address
  always_comb
  begin
    if (pri_is_io_i)
      vga_hit = (pri_addr_i[63:32] == 32'h0000_0000) && vga_io(pri_addr_i[31:0]);
    else
      vga_hit = (pri_addr_i >= VGA_MEM_LO) && (pri_addr_i <= VGA_MEM_HI);
  end

  // downstream decision
  always_comb
  begin
    if (pri_is_io_i)
    begin
      pri_fwd_d = (pri_addr_i[63:32] == 32'h0000_0000) && pri_io_hit;
      if (isa_en_q && isa_alias(pri_addr_i[31:0]))
        pri_fwd_d = 1'b0;
    end
    else
      pri_fwd_d = pf_hit;
    if (vga_en_q && vga_hit)
      pri_fwd_d = 1'b1;
  end

  // upstream decision for secondary I/O
  always_comb
  begin
    sec_fwd_d = !sec_io_hit;
    if (isa_en_q && isa_alias(sec_addr_i))
      sec_fwd_d = 1'b1;
    if (vga_en_q && vga_io(sec_addr_i))
      sec_fwd_d = 1'b0;
  end

  // registered query answers
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pri_done_q <= 1'b0;
      pri_forward_q <= 1'b0;
    end
    else
    begin
      pri_done_q <= pri_valid_i;
      pri_forward_q <= pri_valid_i && pri_fwd_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sec_done_q <= 1'b0;
      sec_forward_q <= 1'b0;
    end
    else
    begin
      sec_done_q <= sec_valid_i;
      sec_forward_q <= sec_valid_i && sec_fwd_d;
    end
  end

  // secondary parity reporting
  // report only when enabled
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      parity_report_q <= 1'b0;
    else
      parity_report_q <= sec_parity_error_i && parity_en_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      serr_n_q <= 1'b1;
    else
      serr_n_q <= !(serr_en_q && !secondary_system_error_n_i);
  end

  assign irq_event[IRQ_PARITY] = sec_parity_error_i && parity_en_q;
  assign irq_event[IRQ_SERR] = serr_en_q && !secondary_system_error_n_i;
  assign status_wr = wr_i && addr_i == OFF_IRQ_STATUS;
  assign mask_wr = wr_i && addr_i == OFF_IRQ_MASK;

  irq_events u_irq
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .event_i(irq_event),
    .status_wr_i(status_wr),
    .mask_wr_i(mask_wr),
    .wdata_i(wdata_i[IRQ_NUM-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // read mux
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (addr_i)
      OFF_PF_BASE_HIGH: rdata_d = pf_base_high_q;
      OFF_PF_LIMIT_HIGH: rdata_d = pf_limit_high_q;
      OFF_IO_HIGH: rdata_d = {io_limit_high_q, io_base_high_q};
      OFF_CAP_PTR: rdata_d = {24'h00_0000, CAP_PTR_VALUE};
      OFF_INT_CTRL:
      begin
        rdata_d[INT_LINE_LSB +: 8] = int_line_q;
        rdata_d[INT_PIN_LSB +: 8] = INT_PIN_VALUE;
        rdata_d[CTRL_PARITY_BIT +: 4] = {vga_en_q, isa_en_q, serr_en_q, parity_en_q};
        rdata_d[CTRL_RSVD_BIT] = 1'b0;
      end
      OFF_IRQ_STATUS: rdata_d[IRQ_NUM-1:0] = irq_status;
      OFF_IRQ_MASK: rdata_d[IRQ_NUM-1:0] = irq_mask;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      rdata_q <= 32'h0000_0000;
    else if (rd_i)
      rdata_q <= rdata_d;
    else
      rdata_q <= 32'h0000_0000;
  end

  assign rdata_o = rdata_q;
  assign pri_done_o = pri_done_q;
  assign pri_forward_o = pri_forward_q;
  assign sec_done_o = sec_done_q;
  assign sec_forward_o = sec_forward_q;
  assign parity_report_o = parity_report_q;
  assign primary_system_error_n_o = serr_n_q;
endmodule

// *** hdl/bridge_regs_pkg.sv ***
package bridge_regs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_PF_BASE_HIGH = 8'h28;
  localparam logic [7:0] OFF_PF_LIMIT_HIGH = 8'h2C;
  localparam logic [7:0] OFF_IO_HIGH = 8'h30;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_INT_CTRL = 8'h3C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
  // reset values
  localparam logic [31:0] PF_HIGH_RESET = 32'h0000_0000;
  localparam logic [15:0] IO_HIGH_RESET = 16'h0000;
  localparam logic [7:0] INT_LINE_RESET = 8'h00;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] CAP_PTR_VALUE = 8'hDC;
  localparam logic [7:0] INT_PIN_VALUE = 8'h00;
  // field positions in the 0x3C word
  localparam int INT_LINE_LSB = 0;
  localparam int INT_PIN_LSB = 8;
  localparam int CTRL_PARITY_BIT = 16;
  localparam int CTRL_SERR_BIT = 17;
  localparam int CTRL_ISA_BIT = 18;
  localparam int CTRL_VGA_BIT = 19;
  localparam int CTRL_RSVD_BIT = 20;
  // io register halves
  localparam int IO_BASE_LSB = 0;
  localparam int IO_LIMIT_LSB = 16;
  // interrupt events
  localparam int IRQ_NUM = 2;
  localparam int IRQ_PARITY = 0;
  localparam int IRQ_SERR = 1;
  // vga compatible ranges
  localparam logic [63:0] VGA_MEM_LO = 64'h0000_0000_000A_0000;
  localparam logic [63:0] VGA_MEM_HI = 64'h0000_0000_000B_FFFF;
  localparam logic [31:0] VGA_IO1_LO = 32'h0000_03B0;
  localparam logic [31:0] VGA_IO1_HI = 32'h0000_03BB;
  localparam logic [31:0] VGA_IO2_LO = 32'h0000_03C0;
  localparam logic [31:0] VGA_IO2_HI = 32'h0000_03DF;
  // window fill for low address bits
  localparam logic [11:0] IO_LOW_ZERO = 12'h000;
  localparam logic [11:0] IO_LOW_ONES = 12'hFFF;
  localparam logic [19:0] PF_LOW_ZERO = 20'h00000;
  localparam logic [19:0] PF_LOW_ONES = 20'hFFFFF;

  // isa alias: first 64KB, last 768 bytes of each 1KB block
  function automatic logic isa_alias(input logic [31:0] addr);
    isa_alias = (addr[31:16] == 16'h0000) && (addr[9:8] != 2'h0);
  endfunction

  function automatic logic vga_io(input logic [31:0] addr);
    vga_io = ((addr >= VGA_IO1_LO) && (addr <= VGA_IO1_HI)) ||
             ((addr >= VGA_IO2_LO) && (addr <= VGA_IO2_HI));
  endfunction
endpackage

// *** hdl/window_compare.sv ***
`timescale 1ns/10ps
module window_compare
#(
  parameter int W = 32
)
(
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] base_i,
  input wire logic [W-1:0] limit_i,
  output logic hit_o
);
  // inclusive base and limit
  assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
endmodule

// *** hdl/irq_events.sv ***
`timescale 1ns/10ps
module irq_events
  import bridge_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [IRQ_NUM-1:0] event_i,
  input wire logic status_wr_i,
  input wire logic mask_wr_i,
  input wire logic [IRQ_NUM-1:0] wdata_i,
  output logic [IRQ_NUM-1:0] status_o,
  output logic [IRQ_NUM-1:0] mask_o,
  output logic irq_o
);
  logic [IRQ_NUM-1:0] status_q;
  logic [IRQ_NUM-1:0] mask_q;

  // sticky bits, set wins over write-one clear
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      status_q <= '0;
    else if (status_wr_i)
      status_q <= (status_q & ~wdata_i) | event_i;
    else
      status_q <= status_q | event_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      mask_q <= '0;
    else if (mask_wr_i)
      mask_q <= wdata_i;
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = |(status_q & mask_q);
endmodule

// *** verification/bridge_regs_assertions.sv ***
`timescale 1ns/10ps
module bridge_regs_assertions
  import bridge_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic pri_valid_i,
  input wire logic pri_is_io_i,
  input wire logic [63:0] pri_addr_i,
  input wire logic pri_done_o,
  input wire logic pri_forward_o,
  input wire logic sec_valid_i,
  input wire logic [31:0] sec_addr_i,
  input wire logic sec_done_o,
  input wire logic sec_forward_o,
  input wire logic sec_parity_error_i,
  input wire logic secondary_system_error_n_i,
  input wire logic parity_report_o,
  input wire logic primary_system_error_n_o,
  input wire logic irq_o
);
  logic [3:0] ctrl_q;
  // shadow of control bits 19:16
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ctrl_q <= 4'h0;
    else if (wr_i && addr_i == OFF_INT_CTRL)
      ctrl_q <= wdata_i[19:16];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_cap_pointer: assert property (rd_i && addr_i == OFF_CAP_PTR |=>
    rdata_o == CAP_PTR_VALUE) else $error("capability pointer readback wrong");
  chk_ctrl_fixed: assert property (rd_i && addr_i == OFF_INT_CTRL |=>
    rdata_o[31:20] == 12'h000 && rdata_o[15:8] == INT_PIN_VALUE) else $error("fixed fields wrong");
  chk_query_done: assert property (pri_done_o == $past(pri_valid_i)
    && sec_done_o == $past(sec_valid_i)) else $error("query answer timing wrong");
  chk_forward_qual: assert property ((pri_forward_o |-> pri_done_o) and
    (sec_forward_o |-> sec_done_o)) else $error("forward without done");
  chk_parity_gate: assert property (parity_report_o ==
    $past(sec_parity_error_i && ctrl_q[0])) else $error("parity report wrong");
  chk_serr_gate: assert property (primary_system_error_n_o ==
    !$past(!secondary_system_error_n_i && ctrl_q[1])) else $error("system error forward wrong");
  chk_isa_block: assert property (pri_valid_i && pri_is_io_i && ctrl_q == 4'h4 &&
    pri_addr_i[63:16] == 48'h0 && pri_addr_i[9:8] != 2'h0 |=> !pri_forward_o)
    else $error("isa alias passed");
  chk_isa_up: assert property (sec_valid_i && ctrl_q == 4'h4 &&
    sec_addr_i[31:16] == 16'h0 && sec_addr_i[9:8] != 2'h0 |=> sec_forward_o)
    else $error("isa alias not sent up");
  chk_vga_mem: assert property (pri_valid_i && !pri_is_io_i && ctrl_q[3] &&
    pri_addr_i >= VGA_MEM_LO && pri_addr_i <= VGA_MEM_HI |=> pri_forward_o)
    else $error("vga not passed");
  chk_mask_off: assert property (wr_i && addr_i == OFF_IRQ_MASK &&
    wdata_i[1:0] == 2'h0 |=> !irq_o) else $error("masked interrupt raised");
  cover property (pri_valid_i && pri_is_io_i && ctrl_q[2]);
  cover property (pri_valid_i && ctrl_q[3]);
  cover property (irq_o);
endmodule

bind bridge_window_and_control_regs bridge_regs_assertions bridge_regs_assertions_inst (.clk_i,
  .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pri_valid_i, .pri_is_io_i, .pri_addr_i,
  .pri_done_o, .pri_forward_o, .sec_valid_i, .sec_addr_i, .sec_done_o, .sec_forward_o,
  .sec_parity_error_i, .secondary_system_error_n_i, .parity_report_o, .primary_system_error_n_o,
  .irq_o);

// *** verification/sec_error_agent.sv ***
`timescale 1ns/10ps
module sec_error_agent
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic par_req_i,
  input wire logic serr_go_i,
  input wire logic [3:0] serr_len_i,
  output logic sec_parity_error_o,
  output logic secondary_system_error_n_o
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_i)
  begin
    sec_parity_error_o <= par_req_i && reset_n_i;
    if (!reset_n_i)
      cnt_q <= 4'h0;
    else if (serr_go_i)
      cnt_q <= serr_len_i;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
  // error held low for the requested span
  assign secondary_system_error_n_o = (cnt_q == 4'h0);
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/10ps
module testbench
  import bridge_regs_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] io_base_low_i = 4'h0;
  logic [3:0] io_limit_low_i = 4'h0;
  logic [11:0] pf_base_low_i = 12'h000;
  logic [11:0] pf_limit_low_i = 12'h000;
  logic pri_valid_i = 1'b0;
  logic pri_is_io_i = 1'b0;
  logic [63:0] pri_addr_i = 64'h0;
  logic sec_valid_i = 1'b0;
  logic [31:0] sec_addr_i = 32'h0;
  logic par_req_i = 1'b0;
  logic serr_go_i = 1'b0;
  logic [3:0] serr_len_i = 4'h0;
  wire logic sec_parity_error_i;
  wire logic secondary_system_error_n_i;
  logic [31:0] rdata_o;
  logic pri_done_o, pri_forward_o, sec_done_o, sec_forward_o;
  logic parity_report_o, primary_system_error_n_o, irq_o;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #2 clk_i = ~clk_i;

  bridge_window_and_control_regs bridge_window_and_control_regs_inst (.clk_i, .reset_n_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .io_base_low_i, .io_limit_low_i, .pf_base_low_i,
    .pf_limit_low_i, .pri_valid_i, .pri_is_io_i, .pri_addr_i, .pri_done_o, .pri_forward_o,
    .sec_valid_i, .sec_addr_i, .sec_done_o, .sec_forward_o, .sec_parity_error_i,
    .secondary_system_error_n_i, .parity_report_o, .primary_system_error_n_o, .irq_o);
  sec_error_agent sec_error_agent_inst (.clk_i, .reset_n_i, .par_req_i, .serr_go_i, .serr_len_i,
    .sec_parity_error_o(sec_parity_error_i),
    .secondary_system_error_n_o(secondary_system_error_n_i));

  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check("rdata", rdata_o, e);
  endtask

  task pq(input logic io, input logic [63:0] a, input logic e);
    @(posedge clk_i);
    pri_valid_i <= 1'b1;
    pri_is_io_i <= io;
    pri_addr_i <= a;
    @(posedge clk_i);
    pri_valid_i <= 1'b0;
    #1;
    check("pri_forward", {pri_done_o, pri_forward_o}, {1'b1, e});
  endtask

  task sq(input logic [31:0] a, input logic e);
    @(posedge clk_i);
    sec_valid_i <= 1'b1;
    sec_addr_i <= a;
    @(posedge clk_i);
    sec_valid_i <= 1'b0;
    #1;
    check("sec_forward", {sec_done_o, sec_forward_o}, {1'b1, e});
  endtask

  task t_reset_values;
    rd(OFF_PF_BASE_HIGH, 32'h0);
    rd(OFF_PF_LIMIT_HIGH, 32'h0);
    rd(OFF_IO_HIGH, 32'h0);
    rd(OFF_CAP_PTR, 32'h0000_00DC);
    rd(OFF_INT_CTRL, 32'h0);
    rd(8'h50, 32'h0);
  endtask

  task t_reg_access;
    wr(OFF_PF_LIMIT_HIGH, 32'hA5A5_5A5A);
    wr(OFF_PF_BASE_HIGH, 32'h5A5A_A5A5);
    wr(OFF_IO_HIGH, 32'h1234_ABCD);
    wr(OFF_CAP_PTR, 32'h0);
    wr(8'h50, 32'hFFFF_FFFF);
    wr(OFF_INT_CTRL, 32'hFFFF_FFFF);
    rd(OFF_PF_LIMIT_HIGH, 32'hA5A5_5A5A);
    rd(OFF_PF_BASE_HIGH, 32'h5A5A_A5A5);
    rd(OFF_IO_HIGH, 32'h1234_ABCD);
    rd(OFF_CAP_PTR, 32'h0000_00DC);
    rd(OFF_INT_CTRL, 32'h000F_00FF);
    rd(8'h50, 32'h0);
    wr(OFF_INT_CTRL, 32'h0);
  endtask

  task t_io_window;
    wr(OFF_IO_HIGH, 32'h0001_0001);
    io_base_low_i <= 4'h2;
    io_limit_low_i <= 4'h3;
    pq(1'b1, 64'h1_1FFF, 1'b0);
    pq(1'b1, 64'h1_2000, 1'b1);
    pq(1'b1, 64'h1_3FFF, 1'b1);
    pq(1'b1, 64'h1_4000, 1'b0);
    pq(1'b1, 64'h1_0001_2000, 1'b0);
    sq(32'h1_1FFF, 1'b1);
    sq(32'h1_2000, 1'b0);
  endtask

  task t_isa;
    wr(OFF_IO_HIGH, 32'h0);
    io_base_low_i <= 4'h0;
    io_limit_low_i <= 4'hF;
    pq(1'b1, 64'h0100, 1'b1);
    wr(OFF_INT_CTRL, 32'h0004_0000);
    pq(1'b1, 64'h0100, 1'b0);
    pq(1'b1, 64'h03FF, 1'b0);
    pq(1'b1, 64'h0400, 1'b1);
    sq(32'h0100, 1'b1);
    sq(32'h0400, 1'b0);
    wr(OFF_INT_CTRL, 32'h0);
  endtask

  task t_vga;
    wr(OFF_IO_HIGH, 32'h0000_0001);
    wr(OFF_PF_BASE_HIGH, 32'h1);
    wr(OFF_PF_LIMIT_HIGH, 32'h0);
    pq(1'b0, 64'hA_0000, 1'b0);
    pq(1'b1, 64'h03C0, 1'b0);
    wr(OFF_INT_CTRL, 32'h0008_0000);
    pq(1'b0, 64'hA_0000, 1'b1);
    pq(1'b0, 64'hB_FFFF, 1'b1);
    pq(1'b0, 64'hC_0000, 1'b0);
    pq(1'b1, 64'h03B0, 1'b1);
    pq(1'b1, 64'h03DF, 1'b1);
    pq(1'b1, 64'h03BC, 1'b0);
    sq(32'h03C0, 1'b0);
    wr(OFF_INT_CTRL, 32'h0);
  endtask

  task t_prefetch;
    wr(OFF_PF_LIMIT_HIGH, 32'h1);
    pq(1'b0, 64'h1_0000_0000, 1'b1);
    pq(1'b0, 64'h1_000F_FFFF, 1'b1);
    pq(1'b0, 64'h1_0010_0000, 1'b0);
    pq(1'b0, 64'h0_FFFF_FFFF, 1'b0);
    @(posedge clk_i);
    pf_base_low_i <= 12'h001;
    pf_limit_low_i <= 12'h002;
    pq(1'b0, 64'h1_000F_FFFF, 1'b0);
    pq(1'b0, 64'h1_0010_0000, 1'b1);
    pq(1'b0, 64'h1_002F_FFFF, 1'b1);
    pq(1'b0, 64'h1_0030_0000, 1'b0);
  endtask

  task t_errors;
    wr(OFF_IRQ_MASK, 32'h3);
    par_req_i <= 1'b1;
    @(posedge clk_i);
    par_req_i <= 1'b0;
    rd(OFF_IRQ_STATUS, 32'h0);
    wr(OFF_INT_CTRL, 32'h0003_0000);
    par_req_i <= 1'b1;
    @(posedge clk_i);
    par_req_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("parity_report", parity_report_o, 1'b1);
    @(posedge clk_i);
    rd(OFF_IRQ_STATUS, 32'h1);
    check("irq", irq_o, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h1);
    rd(OFF_IRQ_STATUS, 32'h0);
    @(posedge clk_i);
    serr_go_i <= 1'b1;
    serr_len_i <= 4'h4;
    @(posedge clk_i);
    serr_go_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check("pri_serr_n", primary_system_error_n_o, 1'b0);
    repeat (4) @(posedge clk_i);
    rd(OFF_IRQ_STATUS, 32'h2);
    wr(OFF_IRQ_MASK, 32'h0);
    #1;
    check("irq", irq_o, 1'b0);
    wr(OFF_IRQ_STATUS, 32'h2);
    wr(OFF_INT_CTRL, 32'h0);
    serr_go_i <= 1'b1;
    @(posedge clk_i);
    serr_go_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check("pri_serr_n", primary_system_error_n_o, 1'b1);
  endtask

  task final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    n_mismatch++;
    final_report;
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset_values;
    t_reg_access;
    t_io_window;
    t_isa;
    t_vga;
    t_prefetch;
    t_errors;
    final_report;
  end
endmodule
